// File: gpd_pkg.sv
// package for the two-group pin data register block
// assumes a 32-bit plain register port and one 125 MHz clock
package gpd_pkg;
    localparam int unsigned GPD_AW = 32;
    localparam int unsigned GPD_DW = 32;
    localparam logic [31:0] GPD_FIRST_GROUP_PIN_DATA_ADDR = 32'hffff0d20;
    localparam logic [31:0] GPD_SECOND_GROUP_PIN_DATA_ADDR = 32'hffff0d30;
    localparam int unsigned GPD_FIVE_PINS = 5;
    localparam int unsigned GPD_TWO_PINS = 2;
    localparam int unsigned GPD_DIR_LSB = 24;
    localparam int unsigned GPD_OUT_LSB = 16;
    localparam int unsigned GPD_IN_LSB = 0;
    // low byte resets undefined; zero chosen so pins start undriven
    localparam logic [4:0] GPD_DIR_RST = 5'h00;
    localparam logic [4:0] GPD_OUT_RST = 5'h00;
    localparam logic [1:0] GPD_SYNC_RST = 2'h0;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } gpd_req_t;
endpackage

// File: gpd_pin_group.sv
// one group of bidirectional pins: direction, output value, input sync
// assumes pin inputs are asynchronous to clock_i
`timescale 1ns/100ps
`default_nettype none
module gpd_pin_group
    import gpd_pkg::*;
#(
    parameter int unsigned N = 5
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic wr_i,
    input wire logic [N-1:0] dir_wdata_i,
    input wire logic [N-1:0] out_wdata_i,
    input wire logic [N-1:0] pin_i,
    output logic [N-1:0] pin_o,
    output logic [N-1:0] pin_oe_o,
    output logic [N-1:0] dir_o,
    output logic [N-1:0] level_o
);
    logic [N-1:0] dir_r;
    logic [N-1:0] out_r;
    logic [N-1:0] meta_r;
    logic [N-1:0] sync_r;

    // ********************
    // direction and value
    // ********************
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dir_r <= N'(GPD_DIR_RST);
        end else if (wr_i) begin
            dir_r <= dir_wdata_i; // see [RULE1] see [RULE4]
        end
    end

    // value kept while input so a later switch drives it at once
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_r <= N'(GPD_OUT_RST);
        end else if (wr_i) begin
            out_r <= out_wdata_i; // see [RULE11]
        end
    end

    // ********************
    // input synchroniser
    // ********************
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
        end
    end

    assign pin_o = out_r; // see [RULE2] see [RULE5]
    assign pin_oe_o = dir_r; // see [RULE11]
    assign dir_o = dir_r;
    assign level_o = sync_r;
endmodule
`default_nettype wire

// File: gpd_port_data.sv
// two pin-data registers for a five-pin and a two-pin group
// assumes a single-master register port, read data one cycle later
// How it works
// [RULE1] five-pin direction in bits 28..24, one=output
// [RULE2] bits 20..16 drive five pins when output
// [RULE3] bits 4..0 read five pin levels
// [RULE4] two-pin direction in bits 25..24
// [RULE5] bits 17..16 drive two pins when output
// [RULE6] bits 1..0 read two pin levels
// [RULE7] software writes zero to status bits
// [RULE8] software writes zero to reserved bits
// [RULE9] one 32-bit word per group, all fields
// [RULE10] same word holds output, returns input status
// [RULE11] keep value while input; undriven until output
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module gpd_port_data
    import gpd_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [4:0] five_pin_group_i,
    output logic [4:0] five_pin_group_o,
    output logic [4:0] five_pin_group_oe_o,
    input wire logic [1:0] two_pin_group_i,
    output logic [1:0] two_pin_group_o,
    output logic [1:0] two_pin_group_oe_o
);
    gpd_req_t req;
    logic sel_first;
    logic sel_second;
    logic [4:0] first_dir;
    logic [4:0] first_lvl;
    logic [1:0] second_dir;
    logic [1:0] second_lvl;
    logic [31:0] rdata_nxt;
    logic [31:0] rdata_r;

    // ********************
    // address decode
    // ********************
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign sel_first = (req.addr == GPD_FIRST_GROUP_PIN_DATA_ADDR);
    assign sel_second = (req.addr == GPD_SECOND_GROUP_PIN_DATA_ADDR);

    // ********************
    // pin groups
    // ********************
    // status bits and reserved bits of the write word are simply dropped
    gpd_pin_group #(.N(GPD_FIVE_PINS)) u_first (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .wr_i(req.wr && sel_first),
        .dir_wdata_i(req.wdata[GPD_DIR_LSB +: GPD_FIVE_PINS]), // see [RULE1]
        .out_wdata_i(req.wdata[GPD_OUT_LSB +: GPD_FIVE_PINS]), // see [RULE2]
        .pin_i(five_pin_group_i),
        .pin_o(five_pin_group_o),
        .pin_oe_o(five_pin_group_oe_o),
        .dir_o(first_dir),
        .level_o(first_lvl)
    );

    gpd_pin_group #(.N(GPD_TWO_PINS)) u_second (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .wr_i(req.wr && sel_second),
        .dir_wdata_i(req.wdata[GPD_DIR_LSB +: GPD_TWO_PINS]), // see [RULE4]
        .out_wdata_i(req.wdata[GPD_OUT_LSB +: GPD_TWO_PINS]), // see [RULE5]
        .pin_i(two_pin_group_i),
        .pin_o(two_pin_group_o),
        .pin_oe_o(two_pin_group_oe_o),
        .dir_o(second_dir),
        .level_o(second_lvl)
    );

    // ********************
    // read back
    // ********************
    // output field reads the stored value, never the pin
    always_comb begin
        rdata_nxt = '0;
        if (sel_first) begin
            rdata_nxt[GPD_DIR_LSB +: GPD_FIVE_PINS] = first_dir; // see [RULE9]
            rdata_nxt[GPD_OUT_LSB +: GPD_FIVE_PINS] =
                five_pin_group_o; // see [RULE10]
            rdata_nxt[GPD_IN_LSB +: GPD_FIVE_PINS] = first_lvl; // see [RULE3]
        end else if (sel_second) begin
            rdata_nxt[GPD_DIR_LSB +: GPD_TWO_PINS] = second_dir;
            rdata_nxt[GPD_OUT_LSB +: GPD_TWO_PINS] =
                two_pin_group_o; // see [RULE10]
            rdata_nxt[GPD_IN_LSB +: GPD_TWO_PINS] = second_lvl; // see [RULE6]
        end
    end

    // read data valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_r <= '0;
        end else if (req.rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= '0;
        end
    end

    assign rdata_o = rdata_r;
endmodule
`default_nettype wire

// File: gpd_monitor.sv
// checker of the pin data register block
// assumes it is bound onto gpd_port_data
`timescale 1ns/100ps
`default_nettype none
module gpd_monitor
    import gpd_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [4:0] five_pin_group_i,
    input wire logic [4:0] five_pin_group_o,
    input wire logic [4:0] five_pin_group_oe_o,
    input wire logic [1:0] two_pin_group_i,
    input wire logic [1:0] two_pin_group_o,
    input wire logic [1:0] two_pin_group_oe_o
);
    // ********
    // assertions
    // ********
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    wire logic at_a = addr_i == GPD_FIRST_GROUP_PIN_DATA_ADDR;
    wire logic at_b = addr_i == GPD_SECOND_GROUP_PIN_DATA_ADDR;
    sequence wr_one; wr_i && at_a; endsequence
    sequence rd_one; rd_i && at_a; endsequence
    sequence rd_two; rd_i && at_b; endsequence
    dir_five_a: assert property (wr_one |=> five_pin_group_oe_o ==
        $past(wdata_i[28:24])) else $error("five dir");
    out_five_a: assert property (wr_one |=> five_pin_group_o ==
        $past(wdata_i[20:16])) else $error("five out");
    // input level is synchronised, so only a pin settled before the read
    in_five_a: assert property ($stable(five_pin_group_i)[*3] ##0 rd_one
        |=> rdata_o[4:0] == $past(five_pin_group_i)) else $error("five in");
    two_wr_a: assert property (wr_i && at_b |=> {two_pin_group_oe_o,
        two_pin_group_o} == $past({wdata_i[25:24], wdata_i[17:16]}))
        else $error("two wr");
    two_rd_a: assert property ($stable(two_pin_group_i)[*3] ##0 rd_two
        |=> rdata_o == {6'h0, $past(two_pin_group_oe_o), 6'h0,
        $past(two_pin_group_o), 14'h0, $past(two_pin_group_i)})
        else $error("two rd");
    word_five_a: assert property (rd_one |=> rdata_o[31:5] == {3'h0,
        $past(five_pin_group_oe_o), 3'h0, $past(five_pin_group_o), 11'h0})
        else $error("five word");
    keep_out_a: assert property (!wr_i |=> $stable(five_pin_group_o)
        && $stable(two_pin_group_oe_o)) else $error("kept");
    idle_rd_a: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("idle rdata");
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the pin data registers
// assumes gpd_port_data and gpd_monitor compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench
    import gpd_pkg::*;
;
    // ********
    // stimulus
    // ********
    localparam logic [31:0] A = GPD_FIRST_GROUP_PIN_DATA_ADDR;
    localparam logic [31:0] B = GPD_SECOND_GROUP_PIN_DATA_ADDR;
    logic clock_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0;
    logic [31:0] addr_i = 0, wdata_i = 0, rdata_o;
    logic [4:0] five_pin_group_i = 5'h15, five_pin_group_o, five_pin_group_oe_o;
    logic [1:0] two_pin_group_i = 2'h2, two_pin_group_o, two_pin_group_oe_o;
    int num_errors = 0, total_checks = 0, cyc = 0;
    gpd_port_data gpd_port_data_i (.*);
    always #4 clock_i = ~clock_i;
    task automatic chk(input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic acc(input logic w, input logic [31:0] a, d);
        @(posedge clock_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'h0;
        rd_i <= 1'h0;
        #1;
        if (!w) chk(rdata_o, d);
    endtask
    task automatic t_first;
        chk({five_pin_group_oe_o, two_pin_group_oe_o}, 0);
        // let the synchroniser fill before the first read
        repeat (2) @(posedge clock_i);
        acc(0, A, 32'h15);
        acc(1, A, 32'h130a0000);
        chk({five_pin_group_oe_o, five_pin_group_o}, 10'h26a);
        acc(0, A, 32'h130a0015);
        @(posedge clock_i);
        five_pin_group_i <= 5'h0a;
        repeat (4) @(posedge clock_i);
        acc(0, A, 32'h130a000a);
    endtask
    task automatic t_second;
        acc(1, B, 32'h02030000);
        chk({two_pin_group_oe_o, two_pin_group_o}, 4'hb);
        acc(0, B, 32'h02030002);
    endtask
    task automatic t_keep;
        acc(1, A, 32'h000a0000);
        acc(1, 32'hffff0d24, 32'hffffffff);
        chk({five_pin_group_oe_o, five_pin_group_o}, 10'h00a);
        acc(0, 32'hffff0d24, 32'h0);
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard: the whole run needs well under 200 cycles
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        repeat (3) @(posedge clock_i);
        reset_n_i <= 1'h1;
        t_first();
        t_second();
        t_keep();
        close_out();
    end
endmodule
bind gpd_port_data gpd_monitor gpd_monitor_i (.*);
`default_nettype wire
